// [core/io_port_pkg.sv]
// constants, layouts and types for the two bidirectional i/o ports
// assumes the core reaches the ports over an axi4-lite slave
package io_port_pkg;
  // register indices, some of them not multiples of four
  localparam logic [7:0] port_a_pin_data_idx = 8'hC0;
  localparam logic [7:0] port_b_pin_data_idx = 8'hC1;
  localparam logic [7:0] port_a_pin_direction_idx = 8'hC4;
  localparam logic [7:0] port_b_pin_direction_idx = 8'hC5;
  localparam logic [7:0] port_a_pin_option_idx = 8'hCC;
  localparam logic [7:0] port_b_pin_option_idx = 8'hCD;
  // control register holding the global interrupt enable, index of our own
  localparam logic [7:0] irq_control_idx = 8'hD0;
  localparam int irq_enable_bit = 0;
  // byte address is four times the index
  localparam int addr_width = 12;
  localparam int word_shift = 2;
  localparam int port_width = 8;
  localparam logic [7:0] port_reset_value = 8'h00;
  localparam logic [7:0] port_a_bonded_mask = 8'h0F;
  localparam logic [7:0] port_b_bonded_mask = 8'hFF;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // per-port configuration carried together
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] opt;
  } port_cfg_t;

  // pad drive for one port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_up;
    logic [7:0] analog;
    logic [7:0] irq_en;
  } port_pad_t;
endpackage

// [core/pin_sync.sv]
// two-flop synchroniser for a bank of pin inputs
// assumes the pins are asynchronous to sys_clk at the board
`timescale 1ns/1ps
module pin_sync (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_level
);
  logic [7:0] stage_one;

  // first stage only feeds the second
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage_one <= 8'h00;
      pin_level <= 8'h00;
    end else if (clk_en) begin
      stage_one <= pin_in; // R23
      pin_level <= stage_one;
    end
  end
endmodule

// [core/port_pad_ctrl.sv]
// per-pin decode of data, direction and option into pad controls
// assumes the caller registers the outputs toward the pins
`timescale 1ns/1ps
module port_pad_ctrl (
  input wire io_port_pkg::port_cfg_t cfg,
  input wire logic [7:0] bonded,
  output io_port_pkg::port_pad_t pad
);
  genvar i;
  generate
    for (i = 0; i < io_port_pkg::port_width; i = i + 1) begin : g_pin
      // output: open-drain only drops the high-side driver
      assign pad.out[i] = cfg.dir[i] & cfg.data[i]; // R03
      assign pad.oe[i] = cfg.dir[i] & (cfg.opt[i] | ~cfg.data[i]); // R01 R04 R08 R21
      // input characteristics come from data and option
      assign pad.pull_up[i] = ~cfg.dir[i] & ~cfg.data[i]; // R06 R07 R10
      assign pad.irq_en[i] = ~cfg.dir[i] & cfg.opt[i] & ~cfg.data[i]; // R07
      assign pad.analog[i] = bonded[i] & ~cfg.dir[i] & cfg.opt[i] & cfg.data[i]; // R07
    end
  endgenerate
endmodule

// [core/io_port_top.sv]
// What this block does
// R01: output pins are driven from the data latch written by software
// R02: reading data of an output pin returns the latch
// R03: push-pull drives both levels; open-drain drives low, floats high
// R04: open-drain is push-pull with the high side switched off
// R05: alternate functions only via software-set direction, option, data
// R06: input, option 0: data 0 pull-up, data 1 plain input
// R07: input, option 1: data 0 pull-up with interrupt, data 1 analog; port a has no analog path and gives a plain input there
// R08: output, option 0 open-drain, option 1 push-pull
// R09: reading data of an input pin returns the live pin level
// R10: writing data of an input pin changes its input characteristics
// R11: software avoids read-modify-write on ports holding inputs
// R12: software keeps a shadow copy of mixed ports in memory
// R13: pin event interrupts only when enabled by config and global enable
// R14: wait or stop keeps pins unchanged; pin interrupt wakes the device
// R15: data and direction registers reset to zero
// R16: data registers at indices C0 and C1
// R17: direction registers at indices C4 and C5
// R18: every register is eight bits, bit n for pin n
// R19: software leaves unbonded bits at reset and masks them
// R20: software avoids direct interrupt-pull-up to analog switching
// R21: direction 0 is input, 1 is output
// R22: option registers at indices CC and CD, reset zero
// R23: pin levels pass two flip-flops before use
//
// two eight-bit ports behind an axi4-lite slave; port a has four pins
// assumes single clock, asynchronous pins, one axi transaction of each kind
`timescale 1ns/1ps
module io_port_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic low_power,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic [3:0] first_port_pins_in,
  output logic [3:0] first_port_pins_out,
  output logic [3:0] first_port_pins_oe,
  output logic [3:0] first_port_pins_pull_up,
  input wire logic [7:0] second_port_pins_in,
  output logic [7:0] second_port_pins_out,
  output logic [7:0] second_port_pins_oe,
  output logic [7:0] second_port_pins_pull_up,
  output logic [7:0] analog_select,
  // level request toward the interrupt controller and wake logic
  output logic pin_irq,
  output logic wake_request
);
  io_port_pkg::port_cfg_t cfg_a, cfg_b;
  io_port_pkg::port_pad_t pad_a, pad_b;
  logic global_irq_enable;
  logic [7:0] level_a, level_b;

  // write channel state: address and data may arrive in either order
  logic aw_held, w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // pin synchronisers, unbonded port a bits read as zero-level inputs
  pin_sync u_sync_a (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .pin_in({4'h0, first_port_pins_in}),
    .pin_level(level_a)
  );
  pin_sync u_sync_b (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .pin_in(second_port_pins_in),
    .pin_level(level_b)
  );

  port_pad_ctrl u_pad_a (
    .cfg(cfg_a),
    .bonded(8'h00),
    .pad(pad_a)
  );
  port_pad_ctrl u_pad_b (
    .cfg(cfg_b),
    .bonded(io_port_pkg::port_b_bonded_mask),
    .pad(pad_b)
  );

  // write decode
  wire wr_fire = aw_held & w_held & ~s_axi_bvalid;
  wire [7:0] wr_idx = aw_addr[9:2];
  wire wr_aligned = (aw_addr[1:0] == 2'h0) & (aw_addr[11:10] == 2'h0);
  wire wr_lane0 = w_strb[0];
  wire sel_w_da = wr_aligned & (wr_idx == io_port_pkg::port_a_pin_data_idx); // R16
  wire sel_w_db = wr_aligned & (wr_idx == io_port_pkg::port_b_pin_data_idx); // R16
  wire sel_w_ra = wr_aligned & (wr_idx == io_port_pkg::port_a_pin_direction_idx); // R17
  wire sel_w_rb = wr_aligned & (wr_idx == io_port_pkg::port_b_pin_direction_idx); // R17
  wire sel_w_oa = wr_aligned & (wr_idx == io_port_pkg::port_a_pin_option_idx); // R22
  wire sel_w_ob = wr_aligned & (wr_idx == io_port_pkg::port_b_pin_option_idx); // R22
  wire sel_w_ic = wr_aligned & (wr_idx == io_port_pkg::irq_control_idx);
  wire wr_hit = sel_w_da | sel_w_db | sel_w_ra | sel_w_rb | sel_w_oa | sel_w_ob | sel_w_ic;
  wire wr_en = wr_fire & wr_lane0 & clk_en;
  wire [7:0] wbyte = w_data[7:0];

  // read decode: inputs show live pin, outputs show the latch
  wire [7:0] rd_idx = s_axi_araddr[9:2];
  wire rd_aligned = (s_axi_araddr[1:0] == 2'h0) & (s_axi_araddr[11:10] == 2'h0);
  wire [7:0] view_a = (cfg_a.dir & cfg_a.data) | (~cfg_a.dir & level_a); // R02 R09
  wire [7:0] view_b = (cfg_b.dir & cfg_b.data) | (~cfg_b.dir & level_b); // R02 R09
  wire rd_hit_da = rd_idx == io_port_pkg::port_a_pin_data_idx;
  wire rd_hit_db = rd_idx == io_port_pkg::port_b_pin_data_idx;
  wire rd_hit_ra = rd_idx == io_port_pkg::port_a_pin_direction_idx;
  wire rd_hit_rb = rd_idx == io_port_pkg::port_b_pin_direction_idx;
  wire rd_hit_oa = rd_idx == io_port_pkg::port_a_pin_option_idx;
  wire rd_hit_ob = rd_idx == io_port_pkg::port_b_pin_option_idx;
  wire rd_hit_ic = rd_idx == io_port_pkg::irq_control_idx;
  wire rd_hit = rd_aligned & (rd_hit_da | rd_hit_db | rd_hit_ra | rd_hit_rb |
    rd_hit_oa | rd_hit_ob | rd_hit_ic);
  wire [7:0] rd_byte = rd_hit_da ? view_a :
    rd_hit_db ? view_b :
    rd_hit_ra ? cfg_a.dir :
    rd_hit_rb ? cfg_b.dir :
    rd_hit_oa ? cfg_a.opt :
    rd_hit_ob ? cfg_b.opt :
    rd_hit_ic ? {7'h00, global_irq_enable} : 8'h00; // R18
  wire rd_take = s_axi_arvalid & s_axi_arready;
  wire [7:0] rd_out = rd_hit ? rd_byte : 8'h00; // unmapped or misaligned reads give zero

  // interrupt: a low level on an interrupt-enabled input with global enable
  wire [7:0] irq_hit_a = pad_a.irq_en & ~level_a & io_port_pkg::port_a_bonded_mask;
  wire [7:0] irq_hit_b = pad_b.irq_en & ~level_b;
  wire next_pin_irq = global_irq_enable & ((|irq_hit_a) | (|irq_hit_b)); // R13

  // register file; unbonded bits stay writable but drive nothing
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_a <= '0; // R15 R22
      cfg_b <= '0; // R15 R22
      global_irq_enable <= 1'b0;
    end else if (wr_en) begin
      if (sel_w_da) cfg_a.data <= wbyte; // R01 R10
      if (sel_w_db) cfg_b.data <= wbyte; // R01 R10
      if (sel_w_ra) cfg_a.dir <= wbyte; // R21
      if (sel_w_rb) cfg_b.dir <= wbyte; // R21
      if (sel_w_oa) cfg_a.opt <= wbyte; // R05
      if (sel_w_ob) cfg_b.opt <= wbyte; // R05
      if (sel_w_ic) global_irq_enable <= wbyte[io_port_pkg::irq_enable_bit];
    end
  end

  // write address and data capture, either order
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response and ready flags
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= io_port_pkg::resp_okay;
    end else if (clk_en) begin
      s_axi_awready <= ~aw_held & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      s_axi_wready <= ~w_held & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? io_port_pkg::resp_okay : io_port_pkg::resp_slverr;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: one outstanding read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= io_port_pkg::resp_okay;
    end else if (clk_en) begin
      s_axi_arready <= ~s_axi_rvalid & ~rd_take;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_out};
        s_axi_rresp <= rd_hit ? io_port_pkg::resp_okay : io_port_pkg::resp_slverr;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // pad registers; low_power is not an input here so pins hold in wait/stop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      first_port_pins_out <= 4'h0;
      first_port_pins_oe <= 4'h0;
      first_port_pins_pull_up <= 4'hF;
      second_port_pins_out <= 8'h00;
      second_port_pins_oe <= 8'h00;
      second_port_pins_pull_up <= 8'hFF;
      analog_select <= 8'h00;
    end else if (clk_en) begin
      first_port_pins_out <= pad_a.out[3:0]; // R03
      first_port_pins_oe <= pad_a.oe[3:0]; // R04 R14
      first_port_pins_pull_up <= pad_a.pull_up[3:0];
      second_port_pins_out <= pad_b.out;
      second_port_pins_oe <= pad_b.oe;
      second_port_pins_pull_up <= pad_b.pull_up; // R06
      analog_select <= pad_b.analog; // R07
    end
  end

  // interrupt level and wake request in low-power states
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_irq <= 1'b0;
      wake_request <= 1'b0;
    end else if (clk_en) begin
      pin_irq <= next_pin_irq; // R13
      wake_request <= next_pin_irq & low_power; // R14
    end
  end

  // checks
  a_irq_needs_enable: assert property (@(posedge sys_clk) disable iff (rst) // R13
    clk_en && !global_irq_enable |=> !pin_irq)
    else $error("pin interrupt raised with global enable clear");
  a_od_high_float: assert property (@(posedge sys_clk) disable iff (rst) // R03
    clk_en && cfg_b.dir[0] && !cfg_b.opt[0] && cfg_b.data[0] |=> !second_port_pins_oe[0])
    else $error("open-drain high drives the pin");
  a_pp_drive: assert property (@(posedge sys_clk) disable iff (rst) // R08
    clk_en && cfg_b.dir[1] && cfg_b.opt[1] |=>
    second_port_pins_oe[1] && second_port_pins_out[1] == $past(cfg_b.data[1]))
    else $error("push-pull pin not driven from latch");
  a_input_no_drive: assert property (@(posedge sys_clk) disable iff (rst) // R21
    clk_en && !cfg_b.dir[2] |=> !second_port_pins_oe[2])
    else $error("input pin driven");
  a_read_output: assert property (@(posedge sys_clk) disable iff (rst) // R02
    clk_en && rd_take && rd_aligned && rd_hit_db && cfg_b.dir[3] |=>
    s_axi_rdata[3] == $past(cfg_b.data[3]))
    else $error("output read not from latch");
  a_read_input: assert property (@(posedge sys_clk) disable iff (rst) // R09
    clk_en && rd_take && rd_aligned && rd_hit_db && !cfg_b.dir[4] |=>
    s_axi_rdata[4] == $past(level_b[4]))
    else $error("input read not from pin");
  a_pullup_mode: assert property (@(posedge sys_clk) disable iff (rst) // R06
    clk_en && !cfg_b.dir[5] && !cfg_b.data[5] |=> second_port_pins_pull_up[5])
    else $error("pull-up missing");
  a_wake_on_irq: assert property (@(posedge sys_clk) disable iff (rst) // R14
    clk_en && low_power && next_pin_irq |=> wake_request)
    else $error("no wake on pin interrupt");
  a_data_write: assert property (@(posedge sys_clk) disable iff (rst) // R16
    wr_en && sel_w_da |=> cfg_a.data == $past(wbyte))
    else $error("port a data write lost");

  // register writes land where decoded and read back whole
  a_data_b_write: assert property (@(posedge sys_clk) disable iff (rst) // R16
    wr_en && sel_w_db |=> cfg_b.data == $past(wbyte))
    else $error("port b data write lost");
  a_dir_write: assert property (@(posedge sys_clk) disable iff (rst) // R17
    wr_en && sel_w_ra |=> cfg_a.dir == $past(wbyte))
    else $error("port a direction write lost");
  a_opt_write: assert property (@(posedge sys_clk) disable iff (rst) // R22
    wr_en && sel_w_ob |=> cfg_b.opt == $past(wbyte))
    else $error("port b option write lost");
  a_read_dir: assert property (@(posedge sys_clk) disable iff (rst) // R17
    clk_en && rd_take && rd_aligned && rd_hit_rb |=>
    s_axi_rdata == {24'h000000, $past(cfg_b.dir)})
    else $error("direction read-back wrong");

  // pad drive against the configuration one edge earlier, or against a data write two edges earlier
  a_od_low_drive: assert property (@(posedge sys_clk) disable iff (rst) // R03
    clk_en && cfg_a.dir[0] && !cfg_a.opt[0] && !cfg_a.data[0] |=>
    first_port_pins_oe[0] && !first_port_pins_out[0])
    else $error("open-drain low not driven");
  a_od_never_high: assert property (@(posedge sys_clk) disable iff (rst) // R04
    clk_en |=> (second_port_pins_oe & second_port_pins_out & ~$past(cfg_b.opt)) == 8'h00)
    else $error("open-drain pin driven high");
  a_pp_drive_a: assert property (@(posedge sys_clk) disable iff (rst) // R01
    clk_en && cfg_a.dir[1] && cfg_a.opt[1] |=>
    first_port_pins_oe[1] && first_port_pins_out[1] == $past(cfg_a.data[1]))
    else $error("port a push-pull pin not driven from latch");
  a_input_a_no_drive: assert property (@(posedge sys_clk) disable iff (rst) // R21
    clk_en |=> (first_port_pins_oe & ~$past(cfg_a.dir[3:0])) == 4'h0)
    else $error("port a input pin driven");
  a_plain_input: assert property (@(posedge sys_clk) disable iff (rst) // R06
    clk_en && !cfg_b.dir[0] && !cfg_b.opt[0] && cfg_b.data[0] |=>
    !second_port_pins_pull_up[0] && !second_port_pins_oe[0])
    else $error("plain input has pull-up or drive");
  a_irq_pullup: assert property (@(posedge sys_clk) disable iff (rst) // R07
    clk_en && !cfg_b.dir[7] && cfg_b.opt[7] && !cfg_b.data[7] |=> second_port_pins_pull_up[7])
    else $error("interrupt input lacks pull-up");
  a_analog_mode: assert property (@(posedge sys_clk) disable iff (rst) // R07
    clk_en && !cfg_b.dir[6] && cfg_b.opt[6] && cfg_b.data[6] |=>
    analog_select[6] && !second_port_pins_pull_up[6])
    else $error("analog input not selected");
  a_input_data_write: assert property (@(posedge sys_clk) disable iff (rst) // R10
    wr_en && sel_w_db && !cfg_b.dir[5] |=>
    ##1 second_port_pins_pull_up[5] == !$past(wbyte[5], 2))
    else $error("data write did not reach input pull-up");

  // interrupt request only from interrupt-enabled inputs; pins hold in low power
  a_irq_raise: assert property (@(posedge sys_clk) disable iff (rst) // R13
    clk_en && global_irq_enable && !cfg_b.dir[7] && cfg_b.opt[7] && !cfg_b.data[7] &&
    !level_b[7] |=> pin_irq)
    else $error("enabled pin interrupt not raised");
  a_irq_only_enabled: assert property (@(posedge sys_clk) disable iff (rst) // R13
    clk_en && ((~cfg_b.dir & cfg_b.opt & ~cfg_b.data) == 8'h00) &&
    ((~cfg_a.dir & cfg_a.opt & ~cfg_a.data & io_port_pkg::port_a_bonded_mask) == 8'h00)
    |=> !pin_irq)
    else $error("pin interrupt from a pin not set for it");
  a_lp_hold: assert property (@(posedge sys_clk) disable iff (rst) // R14
    clk_en && low_power && !wr_en |=> $stable(cfg_a) && $stable(cfg_b))
    else $error("configuration changed in low power");
  a_sync_delay: assert property (@(posedge sys_clk) disable iff (rst) // R23
    clk_en && $past(clk_en) && !$past(rst) |=> level_b == $past(second_port_pins_in, 2))
    else $error("pin level not two flops behind the pin");
endmodule

// [test/pin_model.sv]
// behavioural model of the board around the pins of one port
// assumes pins settle at once; a line nobody drives or pulls toggles each cycle
`timescale 1ns/1ps
module pin_model #(
  parameter int width = 8
) (
  input wire logic sys_clk,
  input wire logic [width-1:0] oe,
  input wire logic [width-1:0] out,
  input wire logic [width-1:0] pull_up,
  input wire logic [width-1:0] ext_en,
  input wire logic [width-1:0] ext_val,
  output logic [width-1:0] level
);
  logic [width-1:0] flt = '0;
  // floating lines wander so that a stale value never reads as a match
  always @(posedge sys_clk) begin
    flt <= ~flt;
  end
  // pad drive wins, then the board drive, then the pull-up
  assign level = (oe & out)
    | (~oe & ext_en & ext_val)
    | (~oe & ~ext_en & pull_up)
    | (~oe & ~ext_en & ~pull_up & flt);
endmodule

// [test/bidir_io_port_config_tb_top.sv]
// self-checking bench for the two i/o ports: axi4-lite master and pin models
// assumes io_port_top with byte address four times the register index
`timescale 1ns/1ps
module bidir_io_port_config_tb_top;
  logic sys_clk, rst, low_power, irq_on;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, pin_irq, wake;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, r;
  logic [3:0] a_out, a_oe, a_pu, a_lvl;
  logic [7:0] b_out, b_oe, b_pu, b_lvl, analog;
  logic [7:0] ext_en [2], ext_val [2], c_dir [2], c_opt [2], c_dat [2];
  int err_total, n_checks, cyc;

  pin_model #(.width(4)) i_pins_a (.sys_clk(sys_clk), .oe(a_oe), .out(a_out), .pull_up(a_pu),
    .ext_en(ext_en[0][3:0]), .ext_val(ext_val[0][3:0]), .level(a_lvl));
  pin_model #(.width(8)) i_pins_b (.sys_clk(sys_clk), .oe(b_oe), .out(b_out), .pull_up(b_pu),
    .ext_en(ext_en[1]), .ext_val(ext_val[1]), .level(b_lvl));
  io_port_top i_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .low_power(low_power),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .first_port_pins_in(a_lvl), .first_port_pins_out(a_out), .first_port_pins_oe(a_oe),
    .first_port_pins_pull_up(a_pu), .second_port_pins_in(b_lvl), .second_port_pins_out(b_out),
    .second_port_pins_oe(b_oe), .second_port_pins_pull_up(b_pu), .analog_select(analog),
    .pin_irq(pin_irq), .wake_request(wake));

  // clock at 25 MHz
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // reset held three cycles, then two edges so the pin synchronisers fill
  task automatic release_reset();
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // write cycle: address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] resp);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rdck(input logic [11:0] a, input logic [7:0] exp, input logic [7:0] m);
    logic [31:0] d;
    logic [1:0] rs;
    rd(a, d, rs);
    chk(d & {24'hFFFFFF, m}, {24'h000000, exp & m}, "read data");
    chk(32'(rs), 32'(io_port_pkg::resp_okay), "read resp");
  endtask

  function automatic logic [11:0] ba(input logic [7:0] idx, input int p);
    return {2'b00, idx + 8'(p), 2'b00};
  endfunction
  function automatic logic [7:0] mk(input int p);
    return p ? io_port_pkg::port_b_bonded_mask : io_port_pkg::port_a_bonded_mask;
  endfunction
  function automatic logic [7:0] x_oe(input int p);
    return c_dir[p] & (c_opt[p] | ~c_dat[p]);
  endfunction
  function automatic logic [7:0] x_pu(input int p);
    return ~c_dir[p] & ~c_dat[p];
  endfunction
  function automatic logic [7:0] x_lvl(input int p);
    return (x_oe(p) & c_dat[p]) | (~x_oe(p) & ext_en[p] & ext_val[p])
      | (~x_oe(p) & ~ext_en[p] & x_pu(p));
  endfunction
  function automatic logic x_irq();
    logic [7:0] hit;
    hit = 8'h00;
    for (int p = 0; p < 2; p++) begin
      hit |= ~c_dir[p] & c_opt[p] & ~c_dat[p] & ~x_lvl(p) & mk(p);
    end
    return irq_on & (|hit);
  endfunction
  // pad drive and read-back of one port against its configuration
  task automatic port_ck(input int p);
    logic [7:0] oe, out, pu;
    oe = p ? b_oe : {4'h0, a_oe};
    out = p ? b_out : {4'h0, a_out};
    pu = p ? b_pu : {4'h0, a_pu};
    chk(32'(oe), 32'(x_oe(p) & mk(p)), "pad enable");
    chk(32'(out & oe), 32'(c_dat[p] & x_oe(p) & mk(p)), "pad level");
    chk(32'(pu & mk(p)), 32'(x_pu(p) & mk(p)), "pull-up");
    if (p == 1) chk(32'(analog), 32'(~c_dir[1] & c_opt[1] & c_dat[1]), "analog");
    rdck(ba(io_port_pkg::port_a_pin_data_idx, p), (c_dir[p] & c_dat[p])
      | (~c_dir[p] & x_lvl(p)), mk(p));
    rdck(ba(io_port_pkg::port_a_pin_direction_idx, p), c_dir[p], 8'hFF);
    rdck(ba(io_port_pkg::port_a_pin_option_idx, p), c_opt[p], 8'hFF);
  endtask

  initial begin
    logic [31:0] d;
    rst = 1'b1;
    low_power = 1'b0;
    irq_on = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {err_total, n_checks, cyc} = '0;
    for (int p = 0; p < 2; p++) begin
      {c_dir[p], c_opt[p], c_dat[p], ext_en[p], ext_val[p]} = '0;
    end
    void'($urandom(4248));
    release_reset();
    port_ck(0);
    port_ck(1);
    $display("test reset values done");
    // unmapped and misaligned places answer with an error and change nothing
    rd(12'h3FC, d, r);
    chk({d[29:0], r}, {30'h0, io_port_pkg::resp_slverr}, "unmapped read");
    wr(12'h302, 8'hFF, r);
    chk(32'(r), 32'(io_port_pkg::resp_slverr), "misaligned write");
    port_ck(0);
    $display("test bad address done");
    for (int i = 0; i < 40; i++) begin
      for (int p = 0; p < 2; p++) begin
        // back to reset: option first, so analog never turns into interrupt input
        wr(ba(io_port_pkg::port_a_pin_option_idx, p), 8'h00, r);
        wr(ba(io_port_pkg::port_a_pin_data_idx, p), 8'h00, r);
        wr(ba(io_port_pkg::port_a_pin_direction_idx, p), 8'h00, r);
        {c_dir[p], c_opt[p], c_dat[p]} = 24'($urandom);
        if (i < 2) c_dir[p] = {8{i == 0}};
        c_dir[p] &= mk(p);
        c_opt[p] &= mk(p);
        c_dat[p] &= mk(p);
        ext_en[p] <= ~c_dir[p] & (8'($urandom) | c_dat[p]) & mk(p);
        ext_val[p] <= 8'($urandom);
        // whole bytes from the bench copy, never read-modify-write
        // data before option, so interrupt input never turns into analog
        wr(ba(io_port_pkg::port_a_pin_data_idx, p), c_dat[p], r);
        wr(ba(io_port_pkg::port_a_pin_option_idx, p), c_opt[p], r);
        wr(ba(io_port_pkg::port_a_pin_direction_idx, p), c_dir[p], r);
      end
      irq_on = 1'($urandom);
      wr({2'b00, io_port_pkg::irq_control_idx, 2'b00}, {7'h00, irq_on}, r);
      chk(32'(r), 32'(io_port_pkg::resp_okay), "write resp");
      low_power <= 1'($urandom);
      repeat (4) @(posedge sys_clk);
      chk(32'(pin_irq), 32'(x_irq()), "irq");
      chk(32'(wake), 32'(x_irq() & low_power), "wake");
      port_ck(0);
      port_ck(1);
    end
    $display("test random configurations done");
    // reset in mid-run clears every register again
    @(posedge sys_clk);
    rst <= 1'b1;
    release_reset();
    irq_on = 1'b0;
    for (int p = 0; p < 2; p++) begin
      {c_dir[p], c_opt[p], c_dat[p]} = '0;
    end
    chk(32'(pin_irq), 32'(x_irq()), "irq after reset");
    port_ck(0);
    port_ck(1);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule
